// File: hdl/nvmac_ctrl.sv
// Byte-wide access controller for the 64-byte non-volatile data memory
`timescale 1ns/100ps
`include "nvmac_defines.svh"

// Summary of operation
// - Sixty-four bytes of storage addressed 0 to 63, separate from other memory.
// - Address register holds six bits; bits 7 and 6 read as zero.
// - Program permit must be one for writes; zero suppresses all writes.
// - Program start begins a write cycle; hardware clears it when done.
// - Program start with permit not already one starts no write.
// - Fetch permit must be one for reads; zero suppresses all reads.
// - Fetch start begins a read cycle unless program start is written with it; hardware clears it when done.
// - Fetch start with permit not already one starts no read.
// - Read byte lands in data register and stays until next access.
// - Write cycle timed internally; completion shown by start clear or flag.
// - Permit and start bits reset to zero; bits 7 to 4 read zero.
// - Cycle end sets done flag and shared flag; request needs three enables.
// - Servicing clears only the shared flag; software clears the done flag.
// - Bank select bit resets to bank 0, hiding the control register.
module nvmac_ctrl #(
   parameter int WRITE_CYCLES = `NVMAC_WRITE_CYCLES,
   parameter int READ_CYCLES  = `NVMAC_READ_CYCLES,
   parameter int DEPTH        = `NVMAC_DEPTH,
   parameter int ADDR_W       = `NVMAC_ADDR_W
) (
   input  wire logic                    ref_clk,
   input  wire logic                    reset,
   input  wire nvmac_pkg::nvmac_sfr_req_s sfr_req,
   input  wire nvmac_pkg::nvmac_irq_ctl_s irq_ctl,
   output logic [7:0]                   sfr_rdata,
   output logic                         nvm_done_flag,
   output logic                         mf_request_flag,
   output logic                         irq_request,
   output logic                         bank_select_bit
);
   import nvmac_pkg::*;

   // Timer width follows the write length, the longer of the two cycles
   localparam int CNT_W = $clog2(WRITE_CYCLES + 1);

   // Storage array; contents survive reset as non-volatile cells would
   // No reset branch on purpose: clearing it would turn every reset into an erase
   // Unwritten cells read unknown in simulation, like a fresh part
   logic [7:0]        nvm_mem [DEPTH];

   // Software-visible registers, sequencer state and working copies
   logic [ADDR_W-1:0] nvm_address_reg;
   logic [7:0]        nvm_data_reg;
   logic              program_permit;
   logic              program_start;
   logic              fetch_permit;
   logic              fetch_start;
   nvmac_state_e      state;
   nvmac_state_e      next_state;
   logic [CNT_W-1:0]  timer;
   logic [ADDR_W-1:0] cyc_addr;
   logic [7:0]        cyc_data;
   logic              cycle_end;

   // Decode results and control strobes
   logic              sel_ctrl;
   logic              sel_addr;
   logic              sel_data;
   logic              sel_bank;
   logic              wr_ctrl;
   logic              start_write;
   logic              start_read;
   logic [7:0]        ctrl_view;

   // Address decode: direct accesses always see bank 0
   // Only the indirect port honours the bank bit, so the control register
   // stays out of reach of any stray direct store
   always_comb begin
      sel_ctrl = sfr_req.indirect && (bank_select_bit == `NVMAC_CONTROL_BANK)
                 && (sfr_req.addr == `NVMAC_OFS_CONTROL);
      sel_addr = (sfr_req.addr == `NVMAC_OFS_ADDRESS)
                 && (!sfr_req.indirect || (bank_select_bit != `NVMAC_CONTROL_BANK));
      sel_data = (sfr_req.addr == `NVMAC_OFS_DATA)
                 && (!sfr_req.indirect || (bank_select_bit != `NVMAC_CONTROL_BANK));
      sel_bank = (sfr_req.addr == `NVMAC_OFS_BANK);
   end

   // Control write and start decisions; permits are judged on their old value
   // A start written together with its permit is refused, so one careless
   // store can never both arm and fire a cycle
   // Starts arriving while a cycle runs are dropped rather than queued
   always_comb begin
      wr_ctrl     = sfr_req.wr && sel_ctrl;
      start_write = wr_ctrl && (state == NVMAC_IDLE) && program_permit
                    && sfr_req.wdata[`NVMAC_BIT_PROG_START];
      start_read  = wr_ctrl && (state == NVMAC_IDLE) && fetch_permit
                    && sfr_req.wdata[`NVMAC_BIT_FETCH_START]
                    && !sfr_req.wdata[`NVMAC_BIT_PROG_START];
   end

   // Bank bit resets to 0 so the control register is hidden after power-up
   // bank select register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bank_select_bit <= `NVMAC_RST_BANK;
      end else if (sfr_req.wr && sel_bank) begin
         bank_select_bit <= sfr_req.wdata[0];
      end
   end

   // Only six address bits are stored; the top two are not kept
   // six bit address register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nvm_address_reg <= `NVMAC_RST_ADDRESS;
      end else if (sfr_req.wr && sel_addr) begin
         nvm_address_reg <= sfr_req.wdata[ADDR_W-1:0];
      end
   end

   // Read end beats a software store in the same cycle, so fetched data
   // is not lost to a store that raced the fetch
   // data register loaded by read end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nvm_data_reg <= `NVMAC_RST_DATA;
      end else if (cycle_end && (state == NVMAC_READ) && fetch_permit) begin
         nvm_data_reg <= nvm_mem[cyc_addr];
      end else if (sfr_req.wr && sel_data) begin
         nvm_data_reg <= sfr_req.wdata;
      end
   end

   // Permit bits follow software writes at any time
   // Dropping a permit mid-cycle lets the cycle run out but cancels its effect
   // Trade-off: the flags still rise, so a cancelled cycle looks finished
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         {program_permit, fetch_permit} <= 2'b00;
      end else if (wr_ctrl) begin
         program_permit <= sfr_req.wdata[`NVMAC_BIT_PROG_PERM];
         fetch_permit   <= sfr_req.wdata[`NVMAC_BIT_FETCH_PERM];
      end
   end

   // Start bits: set only on a taken start, cleared by hardware at the end
   // Software cannot clear a running start bit; only the sequencer ends a cycle
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         {program_start, fetch_start} <= 2'b00;
      end else if (start_write) begin
         program_start <= 1'b1;
      end else if (start_read) begin
         fetch_start <= 1'b1;
      end else if (cycle_end) begin
         program_start <= 1'b0;
         fetch_start   <= 1'b0;
      end
   end

   // Sequencer next state
   // One cycle at a time; reads and writes share the timer and working copies
   always_comb begin
      next_state = state;
      case (state)
         NVMAC_IDLE: begin
            if (start_write) begin
               next_state = NVMAC_WRITE;
            end else if (start_read) begin
               next_state = NVMAC_READ;
            end
         end
         NVMAC_READ,
         NVMAC_WRITE: begin
            if (cycle_end) begin
               next_state = NVMAC_IDLE;
            end
         end
         default: begin
            next_state = NVMAC_IDLE;
         end
      endcase
   end

   // Sequencer state register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state <= NVMAC_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // The write timer counts ref_clk instead of a free-running oscillator;
   // software must still poll or wait for the flag, never count cycles itself
   // internal cycle timer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         timer <= '0;
      end else if (start_write) begin
         timer <= CNT_W'(WRITE_CYCLES - 1);
      end else if (start_read) begin
         timer <= CNT_W'(READ_CYCLES - 1);
      end else if (timer != '0) begin
         timer <= timer - CNT_W'(1);
      end
   end

   // Cycle end stands while the timer rests at zero in a busy state
   assign cycle_end = (state != NVMAC_IDLE) && (timer == '0);

   // Working copies let software set up the next access while one runs
   // capture address and data at start
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cyc_addr <= `NVMAC_RST_ADDRESS;
         cyc_data <= `NVMAC_RST_DATA;
      end else if (start_write || start_read) begin
         cyc_addr <= nvm_address_reg;
         cyc_data <= nvm_data_reg;
      end
   end

   // The array is written once, at the very end, so a cancelled write
   // leaves the old byte untouched
   // storage array commit
   // permit dropped mid-cycle blocks the commit
   always_ff @(posedge ref_clk) begin
      if (cycle_end && (state == NVMAC_WRITE) && program_permit) begin
         nvm_mem[cyc_addr] <= cyc_data;
      end
   end

   // Control register image as the core reads it
   // upper control bits read zero
   assign ctrl_view = {4'h0, program_permit, program_start, fetch_permit, fetch_start};

   // Read port; unmapped offsets answer zero
   // Registered read data holds between reads so the core can sample late
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         if (sel_ctrl) begin
            sfr_rdata <= ctrl_view;
         end else if (sel_addr) begin
            sfr_rdata <= {2'b00, nvm_address_reg};
         end else if (sel_data) begin
            sfr_rdata <= nvm_data_reg;
         end else if (sel_bank) begin
            sfr_rdata <= {7'h00, bank_select_bit};
         end else begin
            sfr_rdata <= 8'h00;
         end
      end
   end

   // Set wins over a clear in the same cycle so a fresh completion is never lost
   // done flag, set beats clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nvm_done_flag <= 1'b0;
      end else if (cycle_end) begin
         nvm_done_flag <= 1'b1;
      end else if (irq_ctl.done_flag_clear) begin
         nvm_done_flag <= 1'b0;
      end
   end

   // Shared flag is this source's share of the multi-function request
   // shared flag set at cycle end
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         mf_request_flag <= 1'b0;
      end else if (cycle_end) begin
         mf_request_flag <= 1'b1;
      end else if (irq_ctl.mf_service_ack) begin
         mf_request_flag <= 1'b0;
      end
   end

   // Own flag and shared flag must both stand; the request lags them one clock
   // request gated by all three enables
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         irq_request <= 1'b0;
      end else begin
         irq_request <= nvm_done_flag && mf_request_flag && irq_ctl.done_irq_enable
                        && irq_ctl.mf_irq_enable && irq_ctl.global_irq_enable;
      end
   end

endmodule

// File: hdl/nvmac_defines.svh
// Offsets, field positions, reset values and timing defaults of the data memory controller
`ifndef NVMAC_DEFINES_SVH
`define NVMAC_DEFINES_SVH

// Register offsets in the special function space
`define NVMAC_OFS_CONTROL     8'h40
`define NVMAC_OFS_ADDRESS     8'h2A
`define NVMAC_OFS_DATA        8'h2B
`define NVMAC_OFS_BANK        8'h04

// Control register field positions
`define NVMAC_BIT_FETCH_START 0
`define NVMAC_BIT_FETCH_PERM  1
`define NVMAC_BIT_PROG_START  2
`define NVMAC_BIT_PROG_PERM   3

// Memory geometry
`define NVMAC_DEPTH           64
`define NVMAC_ADDR_W          6

// Reset values
`define NVMAC_RST_CONTROL     4'h0
`define NVMAC_RST_ADDRESS     6'h00
`define NVMAC_RST_DATA        8'h00
`define NVMAC_RST_BANK        1'b0

// Bank in which the control register lives
`define NVMAC_CONTROL_BANK    1'b1

// Cycle counts of the internal access timers
`define NVMAC_WRITE_CYCLES    1000
`define NVMAC_READ_CYCLES     4

`endif

// File: hdl/nvmac_pkg.sv
// Types shared by the data memory controller and its surroundings
package nvmac_pkg;

   // Special function access from the core, one request per cycle
   typedef struct packed {
      logic [7:0] addr;
      logic       indirect;
      logic       wr;
      logic       rd;
      logic [7:0] wdata;
   } nvmac_sfr_req_s;

   // Interrupt enables and acknowledges from the interrupt controller
   typedef struct packed {
      logic done_irq_enable;
      logic mf_irq_enable;
      logic global_irq_enable;
      logic done_flag_clear;
      logic mf_service_ack;
   } nvmac_irq_ctl_s;

   // Access sequencer states
   typedef enum logic [1:0] {
      NVMAC_IDLE  = 2'b00,
      NVMAC_READ  = 2'b01,
      NVMAC_WRITE = 2'b10
   } nvmac_state_e;

endpackage

// File: bench/nvmac_ctrl_chk.sv
// Port-level assertions for the data memory access controller
`timescale 1ns/100ps
`include "nvmac_defines.svh"
module nvmac_ctrl_chk (
   input wire logic                      ref_clk,
   input wire logic                      reset,
   input wire nvmac_pkg::nvmac_sfr_req_s sfr_req,
   input wire nvmac_pkg::nvmac_irq_ctl_s irq_ctl,
   input wire logic [7:0]                sfr_rdata,
   input wire logic                      nvm_done_flag,
   input wire logic                      mf_request_flag,
   input wire logic                      irq_request,
   input wire logic                      bank_select_bit
);
   import nvmac_pkg::*;
   logic ctl_vis;
   // Control register is seen only through the indirect port in bank 1
   assign ctl_vis = sfr_req.indirect & bank_select_bit;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   a_irq_all_enables: assert property (
      irq_request == $past(nvm_done_flag & mf_request_flag & irq_ctl.done_irq_enable
                           & irq_ctl.mf_irq_enable & irq_ctl.global_irq_enable))
      else $error("irq request does not follow flags and enables");
   a_flags_together: assert property ($rose(nvm_done_flag) |-> mf_request_flag)
      else $error("done flag rose without shared flag");
   a_mf_ack_only: assert property ($fell(mf_request_flag) |-> $past(irq_ctl.mf_service_ack))
      else $error("shared flag fell without service");
   a_done_sw_clear: assert property (
      $fell(nvm_done_flag) |-> $past(irq_ctl.done_flag_clear))
      else $error("done flag fell without software clear");
   a_rdata_holds: assert property (!$past(sfr_req.rd) |-> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_bank_write: assert property (
      sfr_req.wr && sfr_req.addr == `NVMAC_OFS_BANK |=> bank_select_bit == $past(sfr_req.wdata[0]))
      else $error("bank select did not take written bit");
   a_addr_upper: assert property (
      sfr_req.rd && sfr_req.addr == `NVMAC_OFS_ADDRESS && !ctl_vis |=> sfr_rdata[7:6] == 2'b00)
      else $error("address upper bits not zero");
   a_ctrl_upper: assert property (
      sfr_req.rd && sfr_req.addr == `NVMAC_OFS_CONTROL && ctl_vis |=> sfr_rdata[7:4] == 4'h0)
      else $error("control upper bits not zero");
   a_ctrl_hidden: assert property (
      sfr_req.rd && sfr_req.addr == `NVMAC_OFS_CONTROL && !ctl_vis |=> sfr_rdata == 8'h00)
      else $error("control visible outside bank 1");
endmodule

bind nvmac_ctrl nvmac_ctrl_chk nvmac_ctrl_chk_inst (
   .ref_clk(ref_clk), .reset(reset), .sfr_req(sfr_req), .irq_ctl(irq_ctl),
   .sfr_rdata(sfr_rdata), .nvm_done_flag(nvm_done_flag), .mf_request_flag(mf_request_flag),
   .irq_request(irq_request), .bank_select_bit(bank_select_bit));

// File: bench/tb_nvmac_ctrl.sv
// Self-checking bench for the data memory access controller
`timescale 1ns/100ps
`include "nvmac_defines.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module tb_nvmac_ctrl;
   import nvmac_pkg::*;
   logic           ref_clk = 1'b0;
   logic           reset = 1'b1;
   nvmac_sfr_req_s sfr_req = '0;
   nvmac_irq_ctl_s irq_ctl = '0;
   logic [7:0]     sfr_rdata;
   logic           nvm_done_flag;
   logic           mf_request_flag;
   logic           irq_request;
   logic           bank_select_bit;
   logic [7:0]     mem [64];
   logic [5:0]     al [6];
   logic [7:0]     rv;
   logic [7:0]     d;
   logic [2:0]     en;
   int             num_errors = 0;
   int             checked = 0;
   always #20 ref_clk = ~ref_clk;
   // Write cycle kept long enough for a mid-cycle access and a status read
   nvmac_ctrl #(.WRITE_CYCLES(10), .READ_CYCLES(2), .DEPTH(64), .ADDR_W(6)) nvmac_ctrl_inst (
      .ref_clk(ref_clk), .reset(reset), .sfr_req(sfr_req), .irq_ctl(irq_ctl),
      .sfr_rdata(sfr_rdata), .nvm_done_flag(nvm_done_flag), .mf_request_flag(mf_request_flag),
      .irq_request(irq_request), .bank_select_bit(bank_select_bit));
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // One access, strobe up for exactly one taking edge; read data sampled after it
   task automatic sfr(input logic [7:0] ad, input logic ind, input logic w, input logic [7:0] wd);
      @(posedge ref_clk);
      sfr_req <= '{addr: ad, indirect: ind, wr: w, rd: !w, wdata: wd};
      @(posedge ref_clk);
      sfr_req <= '0;
      #1;
      rv = sfr_rdata;
   endtask
   // Poll a start bit; a hang ends the run as a failure
   task automatic wait_clear(input int bitn);
      for (int i = 0; i < 40; i++) begin
         sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
         if (rv[bitn] === 1'b0) return;
      end
      num_errors++;
      end_sim();
   endtask
   task automatic pulse(input logic ack, input logic clr);
      @(posedge ref_clk);
      irq_ctl[1:0] <= {clr, ack};
      @(posedge ref_clk);
      irq_ctl[1:0] <= 2'b00;
      #1;
   endtask
   // Address and data are disturbed mid-cycle to prove both were captured at start
   task automatic nv_write(input logic [5:0] wa, input logic [7:0] wd, input logic [7:0] mid);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h08);
      sfr(`NVMAC_OFS_ADDRESS, 1'b0, 1'b1, {2'b00, wa});
      sfr(`NVMAC_OFS_DATA, 1'b0, 1'b1, wd);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h0C);
      sfr(`NVMAC_OFS_ADDRESS, 1'b0, 1'b1, {2'b00, ~wa});
      sfr(`NVMAC_OFS_DATA, 1'b0, 1'b1, ~wd);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, mid);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
      `CHK("ctl_busy", mid | 8'h04, rv)
      wait_clear(2);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h00);
   endtask
   task automatic nv_read(input logic [5:0] ra);
      sfr(`NVMAC_OFS_ADDRESS, 1'b0, 1'b1, {2'b00, ra});
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h02);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h03);
      wait_clear(0);
      sfr(`NVMAC_OFS_DATA, 1'b0, 1'b0, 8'h00);
   endtask
   initial begin
      void'($urandom(32'h54BA8795));
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      #1;
      `CHK("bank_rst", 1'b0, bank_select_bit)
      `CHK("flags_rst", 3'b000, {nvm_done_flag, mf_request_flag, irq_request})
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
      `CHK("ctl_bank0", 8'h00, rv)
      sfr(`NVMAC_OFS_BANK, 1'b0, 1'b1, 8'h01);
      `CHK("bank_set", 1'b1, bank_select_bit)
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
      `CHK("ctl_rst", 8'h00, rv)
      sfr(8'hFF, 1'b0, 1'b0, 8'h00);
      `CHK("unmapped", 8'h00, rv)
      d = 8'($urandom);
      sfr(`NVMAC_OFS_ADDRESS, 1'b0, 1'b1, d);
      sfr(`NVMAC_OFS_ADDRESS, 1'b0, 1'b0, 8'h00);
      `CHK("addr_rb", {2'b00, d[5:0]}, rv)
      // Starts without a prior permit are ignored
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h04);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
      `CHK("prog_noperm", 8'h00, rv)
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b1, 8'h01);
      sfr(`NVMAC_OFS_CONTROL, 1'b1, 1'b0, 8'h00);
      `CHK("fetch_noperm", 8'h00, rv)
      for (int i = 0; i < 6; i++) begin
         al[i] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
         d = 8'($urandom);
         en = 3'($urandom);
         @(posedge ref_clk);
         irq_ctl[4:2] <= en;
         nv_write(al[i], d, 8'h08);
         mem[al[i]] = d;
         `CHK("flags_wr", 2'b11, {nvm_done_flag, mf_request_flag})
         `CHK("irq", &en, irq_request)
         pulse(1'b1, 1'b0);
         `CHK("svc_keeps", 2'b10, {nvm_done_flag, mf_request_flag})
         pulse(1'b0, 1'b1);
         `CHK("sw_clear", 1'b0, nvm_done_flag)
      end
      // Permit dropped mid-cycle: the cycle ends but nothing is stored
      nv_write(al[2], ~mem[al[2]], 8'h00);
      pulse(1'b1, 1'b1);
      for (int i = 0; i < 6; i++) begin
         nv_read(al[i]);
         `CHK("rd_data", mem[al[i]], rv)
         `CHK("flags_rd", 2'b11, {nvm_done_flag, mf_request_flag})
         pulse(1'b1, 1'b1);
         sfr(`NVMAC_OFS_DATA, 1'b0, 1'b0, 8'h00);
         `CHK("rd_hold", mem[al[i]], rv)
      end
      end_sim();
   end
endmodule
